// ===== rtl/clk_ratio_pkg.sv
/*
  constants, types and state layout for the core clock ratio control block.
  assumes one bus clock (mclk) and a classic wishbone register slave.
*/
// How it works
// - ratio codes 100110..110010 give core multipliers 11x to 14x.
// - ratio codes 000110..111010 give core multipliers 15x to 28x.
// - code 001100: pll disabled, core clocked straight from the bus clock.
// - code 111100: pll off, no core clocking whatever the bus clock does.
// - in bypass, processor bus runs at half the input clock, core at full.
// - listed multipliers hold only with frequency switching off.
package clk_ratio_pkg;

  // ratio select encodings
  localparam logic [5:0] RS_11X = 6'h26;
  localparam logic [5:0] RS_11P5X = 6'h00;
  localparam logic [5:0] RS_12X = 6'h2e;
  localparam logic [5:0] RS_12P5X = 6'h3e;
  localparam logic [5:0] RS_13X = 6'h16;
  localparam logic [5:0] RS_13P5X = 6'h38;
  localparam logic [5:0] RS_14X = 6'h32;
  localparam logic [5:0] RS_15X = 6'h06;
  localparam logic [5:0] RS_16X = 6'h36;
  localparam logic [5:0] RS_17X = 6'h02;
  localparam logic [5:0] RS_18X = 6'h0a;
  localparam logic [5:0] RS_20X = 6'h0e;
  localparam logic [5:0] RS_21X = 6'h12;
  localparam logic [5:0] RS_24X = 6'h1a;
  localparam logic [5:0] RS_28X = 6'h3a;
  localparam logic [5:0] RS_BYPASS = 6'h0c;
  localparam logic [5:0] RS_OFF = 6'h3c;

  // multipliers in half steps (value = 2 * multiplier)
  localparam logic [7:0] MX2_11 = 8'h16;
  localparam logic [7:0] MX2_11P5 = 8'h17;
  localparam logic [7:0] MX2_12 = 8'h18;
  localparam logic [7:0] MX2_12P5 = 8'h19;
  localparam logic [7:0] MX2_13 = 8'h1a;
  localparam logic [7:0] MX2_13P5 = 8'h1b;
  localparam logic [7:0] MX2_14 = 8'h1c;
  localparam logic [7:0] MX2_15 = 8'h1e;
  localparam logic [7:0] MX2_16 = 8'h20;
  localparam logic [7:0] MX2_17 = 8'h22;
  localparam logic [7:0] MX2_18 = 8'h24;
  localparam logic [7:0] MX2_20 = 8'h28;
  localparam logic [7:0] MX2_21 = 8'h2a;
  localparam logic [7:0] MX2_24 = 8'h30;
  localparam logic [7:0] MX2_28 = 8'h38;
  localparam logic [7:0] MX2_1 = 8'h02;
  localparam logic [7:0] MX2_NONE = 8'h00;

  // register map (byte addresses)
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;

  // ctrl fields: dynamic frequency switching enable and divide
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_SW_DIV_LO = 1;
  localparam int CTRL_SW_DIV_HI = 2;
  // status fields
  localparam int ST_SEL_LO = 0;
  localparam int ST_SEL_HI = 5;
  localparam int ST_MODE_LO = 6;
  localparam int ST_MODE_HI = 7;
  localparam int ST_RSVD = 8;
  localparam int ST_MULT_LO = 16;
  localparam int ST_MULT_HI = 23;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PLL,
    MODE_BYPASS
  } clk_mode_t;

  typedef struct packed {
    logic [7:0] mult_x2;
    clk_mode_t mode;
    logic reserved;
  } ratio_dec_t;

  typedef struct packed {
    logic captured;
    logic [5:0] sel;
    logic sw_en;
    logic [1:0] sw_div;
    logic ack;
    logic [31:0] rdat;
    logic core_en;
    logic bus_en;
    logic pll_en;
    logic [7:0] mult_x2;
    clk_mode_t mode;
    logic reserved;
  } ratio_state_t;

  localparam ratio_state_t STATE_RESET = '{
    captured: 1'b0, sel: RS_OFF, sw_en: 1'b0, sw_div: 2'h0,
    ack: 1'b0, rdat: 32'h0, core_en: 1'b0, bus_en: 1'b0, pll_en: 1'b0,
    mult_x2: MX2_NONE, mode: MODE_OFF, reserved: 1'b0};

endpackage

// ===== rtl/ratio_decode.sv
/*
  combinational decode of the six-bit ratio select into multiplier and mode.
  assumes the select is already held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module ratio_decode (
  input wire logic [5:0] sel, // ratio select code
  output var clk_ratio_pkg::ratio_dec_t dec // multiplier, mode, reserved flag
);
  always_comb begin
    dec.mult_x2 = clk_ratio_pkg::MX2_NONE;
    dec.mode = clk_ratio_pkg::MODE_PLL;
    dec.reserved = 1'b0;
    unique case (sel)
      clk_ratio_pkg::RS_11X: dec.mult_x2 = clk_ratio_pkg::MX2_11;
      clk_ratio_pkg::RS_11P5X: dec.mult_x2 = clk_ratio_pkg::MX2_11P5;
      clk_ratio_pkg::RS_12X: dec.mult_x2 = clk_ratio_pkg::MX2_12;
      clk_ratio_pkg::RS_12P5X: dec.mult_x2 = clk_ratio_pkg::MX2_12P5;
      clk_ratio_pkg::RS_13X: dec.mult_x2 = clk_ratio_pkg::MX2_13;
      clk_ratio_pkg::RS_13P5X: dec.mult_x2 = clk_ratio_pkg::MX2_13P5;
      clk_ratio_pkg::RS_14X: dec.mult_x2 = clk_ratio_pkg::MX2_14;
      clk_ratio_pkg::RS_15X: dec.mult_x2 = clk_ratio_pkg::MX2_15;
      clk_ratio_pkg::RS_16X: dec.mult_x2 = clk_ratio_pkg::MX2_16;
      clk_ratio_pkg::RS_17X: dec.mult_x2 = clk_ratio_pkg::MX2_17;
      clk_ratio_pkg::RS_18X: dec.mult_x2 = clk_ratio_pkg::MX2_18;
      clk_ratio_pkg::RS_20X: dec.mult_x2 = clk_ratio_pkg::MX2_20;
      clk_ratio_pkg::RS_21X: dec.mult_x2 = clk_ratio_pkg::MX2_21;
      clk_ratio_pkg::RS_24X: dec.mult_x2 = clk_ratio_pkg::MX2_24;
      clk_ratio_pkg::RS_28X: dec.mult_x2 = clk_ratio_pkg::MX2_28;
      clk_ratio_pkg::RS_BYPASS: begin
        dec.mult_x2 = clk_ratio_pkg::MX2_1;
        dec.mode = clk_ratio_pkg::MODE_BYPASS;
      end
      clk_ratio_pkg::RS_OFF: dec.mode = clk_ratio_pkg::MODE_OFF;
      default: begin
        // reserved codes fail safe: treat like pll off
        dec.mode = clk_ratio_pkg::MODE_OFF;
        dec.reserved = 1'b1;
      end
    endcase
  end
endmodule // ratio_decode
`default_nettype wire

// ===== rtl/clk_ratio_ctrl.sv
/*
  core clock ratio control: captures the ratio select after reset, decodes
  it, drives pll enable, core and bus clock enables and the effective
  multiplier, and offers ctrl/status over a classic wishbone slave.
  assumes ratio select, qualifier and bus inputs are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_ratio_ctrl (
  input wire logic mclk, // bus clock, 10 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [5:0] ratio_select, // ratio select straps
  input wire logic bypass_half_rate_qualifier, // half-rate bus qualifier
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte enables
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic pll_enable, // pll running
  output logic core_clk_en, // core clock enable
  output logic bus_clk_en, // processor bus clock enable
  output logic [7:0] core_mult_x2, // effective multiplier times two
  output logic ratio_reserved // reserved code applied
);
  clk_ratio_pkg::ratio_state_t st_r;
  clk_ratio_pkg::ratio_state_t st_nxt;
  clk_ratio_pkg::ratio_dec_t dec;
  logic req;
  logic [7:0] eff_mult;

  ratio_decode u_dec (
    .sel(st_r.sel),
    .dec(dec)
  );

  assign req = wb_cyc_i & wb_stb_i;
  // frequency switching divides the core multiplier by 2^sw_div
  assign eff_mult = st_r.sw_en ? (dec.mult_x2 >> st_r.sw_div)
                               : dec.mult_x2;

  always_comb begin
    st_nxt = st_r;
    // straps caught once, on the first edge after reset release
    if (!st_r.captured) begin
      st_nxt.captured = 1'b1;
      st_nxt.sel = ratio_select;
    end
    st_nxt.mode = dec.mode;
    st_nxt.reserved = dec.reserved;
    st_nxt.mult_x2 = eff_mult;
    unique case (dec.mode)
      clk_ratio_pkg::MODE_PLL: begin
        st_nxt.pll_en = 1'b1;
        st_nxt.core_en = 1'b1;
        st_nxt.bus_en = 1'b1;
      end
      clk_ratio_pkg::MODE_BYPASS: begin
        st_nxt.pll_en = 1'b0;
        st_nxt.core_en = 1'b1;
        // bus advances only on qualifier cycles: half the input rate
        st_nxt.bus_en = bypass_half_rate_qualifier;
      end
      clk_ratio_pkg::MODE_OFF: begin
        st_nxt.pll_en = 1'b0;
        st_nxt.core_en = 1'b0;
        st_nxt.bus_en = 1'b0;
      end
      default: begin
        st_nxt.pll_en = 1'b0;
        st_nxt.core_en = 1'b0;
        st_nxt.bus_en = 1'b0;
      end
    endcase
    // wishbone: ack one cycle after request, dropped the cycle after
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.rdat = 32'h0;
    if (req && !st_r.ack && !wb_we_i) begin
      if (wb_adr_i == clk_ratio_pkg::ADR_CTRL) begin
        st_nxt.rdat[clk_ratio_pkg::CTRL_SW_EN] = st_r.sw_en;
        st_nxt.rdat[clk_ratio_pkg::CTRL_SW_DIV_HI:
                    clk_ratio_pkg::CTRL_SW_DIV_LO] = st_r.sw_div;
      end else if (wb_adr_i == clk_ratio_pkg::ADR_STATUS) begin
        st_nxt.rdat[clk_ratio_pkg::ST_SEL_HI:clk_ratio_pkg::ST_SEL_LO] =
          st_r.sel;
        st_nxt.rdat[clk_ratio_pkg::ST_MODE_HI:clk_ratio_pkg::ST_MODE_LO] =
          st_r.mode;
        st_nxt.rdat[clk_ratio_pkg::ST_RSVD] = st_r.reserved;
        st_nxt.rdat[clk_ratio_pkg::ST_MULT_HI:clk_ratio_pkg::ST_MULT_LO] =
          st_r.mult_x2;
      end
    end
    // writes land on the edge where the master sees ack
    if (req && st_r.ack && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == clk_ratio_pkg::ADR_CTRL) begin
      st_nxt.sw_en = wb_dat_i[clk_ratio_pkg::CTRL_SW_EN];
      st_nxt.sw_div = wb_dat_i[clk_ratio_pkg::CTRL_SW_DIV_HI:
                               clk_ratio_pkg::CTRL_SW_DIV_LO];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= clk_ratio_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign pll_enable = st_r.pll_en;
  assign core_clk_en = st_r.core_en;
  assign bus_clk_en = st_r.bus_en;
  assign core_mult_x2 = st_r.mult_x2;
  assign ratio_reserved = st_r.reserved;

  // checks
  // each strap antecedent samples the captured code one edge before the outputs
  sequence s_sel_low;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_11X && !st_r.sw_en;
  endsequence

  sequence s_sel_top_low;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_14X && !st_r.sw_en;
  endsequence

  sequence s_sel_base_high;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_15X && !st_r.sw_en;
  endsequence

  sequence s_sel_high;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_28X && !st_r.sw_en;
  endsequence

  sequence s_bypass;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_BYPASS;
  endsequence

  sequence s_off;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_OFF;
  endsequence

  sequence s_rsvd;
    st_r.captured && dec.reserved;
  endsequence

  sequence s_switch_half;
    st_r.captured && st_r.sel == clk_ratio_pkg::RS_24X && st_r.sw_en &&
      st_r.sw_div == 2'h1;
  endsequence

  // a request with no acknowledge standing is taken on this edge
  sequence s_req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_mult_eleven: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_sel_low |=> core_mult_x2 == clk_ratio_pkg::MX2_11 &&
      pll_enable && core_clk_en)
    else $error("11x code did not give multiplier 11");

  a_mult_fourteen: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_sel_top_low |=> core_mult_x2 == clk_ratio_pkg::MX2_14 && bus_clk_en)
    else $error("14x code did not give multiplier 14");

  a_mult_fifteen: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_sel_base_high |=> core_mult_x2 == clk_ratio_pkg::MX2_15 && pll_enable)
    else $error("15x code did not give multiplier 15");

  a_mult_twentyeight: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_sel_high |=> core_mult_x2 == clk_ratio_pkg::MX2_28 && bus_clk_en)
    else $error("28x code did not give multiplier 28");

  a_bypass_core_direct: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_bypass ##1 s_bypass |-> !pll_enable && core_clk_en &&
      core_mult_x2 == clk_ratio_pkg::MX2_1)
    else $error("bypass did not clock core from bus clock");

  a_off_no_clock: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_off ##1 s_off |-> !pll_enable && !core_clk_en && !bus_clk_en &&
      core_mult_x2 == clk_ratio_pkg::MX2_NONE)
    else $error("pll off still clocking");

  // reserved codes fail safe: everything stays stopped
  a_reserved_stops: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_rsvd |=> ratio_reserved && !pll_enable && !core_clk_en && !bus_clk_en)
    else $error("reserved code did not stop the clocks");

  a_bypass_half_bus: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_bypass |=> bus_clk_en == $past(bypass_half_rate_qualifier))
    else $error("bypass bus enable does not follow qualifier");

  a_switch_divides: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_switch_half |=> core_mult_x2 == clk_ratio_pkg::MX2_12)
    else $error("frequency switching did not halve 24x");

  a_ack_follows_req: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_req_taken |=> wb_ack_o)
    else $error("request not acknowledged on the next edge");

  a_ack_one_cycle: assert property (
    @(posedge mclk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge stood longer than one cycle");

  a_rdat_idle_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");

  // straps are caught once; a later board change must not leak in
  a_sel_held: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_r.captured |=> $stable(st_r.sel))
    else $error("captured ratio select changed after capture");

endmodule // clk_ratio_ctrl
`default_nettype wire

// ===== test/board_model.sv
/*
  board side model: presents the ratio straps and the half-rate qualifier.
  the bench changes the strap value while reset is held, and once more after capture.
*/
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input wire logic mclk, // bus clock
  input wire logic [5:0] code, // strap value to present
  input wire logic qual_run, // run the qualifier
  input wire logic [7:0] core_mult, // core multiplier x2 from the block
  output logic [5:0] ratio_select, // strap outputs
  output logic bypass_half_rate_qualifier, // half-rate qualifier
  output logic [1:0] addr_acknowledge_delay // acknowledge hold-off cycles
);
  // bench moves straps under reset and once after capture; a reserved code is a refusal test
  assign ratio_select = code;
  // below 5x the core cannot answer a snoop in time, so the model asks
  // for the address acknowledge to be held back one bus cycle
  assign addr_acknowledge_delay =
    (core_mult != 8'h00 && core_mult < 8'h0a) ? 2'h1 : 2'h0;
  initial bypass_half_rate_qualifier = 1'b0;
  // toggling each edge gives half the bus rate, shifted off the edge
  always @(posedge mclk) begin
    if (qual_run) begin
      bypass_half_rate_qualifier <= ~bypass_half_rate_qualifier;
    end
  end
endmodule // board_model
`default_nettype wire

// ===== test/clk_ratio_ctrl_tb.sv
/*
  testbench for clk_ratio_ctrl: strap decode, bypass, ctrl/status access.
  assumes board_model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_ratio_ctrl_tb;
  logic mclk, arst_n, cyc, stb, we, qual_run, ack, pll, core_en, bus_en;
  logic rsvd, qual, q;
  logic [5:0] code, rsel;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, d;
  logic [7:0] mult;
  logic [1:0] ack_dly;
  int err_count = 0, n_tests = 0, cyc_n = 0, i;
  logic [5:0] codes [18] = '{6'h26, 6'h00, 6'h2e, 6'h3e, 6'h16, 6'h38,
    6'h32, 6'h06, 6'h36, 6'h02, 6'h0a, 6'h0e, 6'h12, 6'h1a, 6'h3a, 6'h0c,
    6'h3c, 6'h01};
  logic [7:0] mx2 [18] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c,
    8'h1e, 8'h20, 8'h22, 8'h24, 8'h28, 8'h2a, 8'h30, 8'h38, 8'h02, 8'h00,
    8'h00};

  board_model bm (.mclk(mclk), .code(code), .qual_run(qual_run),
    .core_mult(mult), .ratio_select(rsel),
    .bypass_half_rate_qualifier(qual), .addr_acknowledge_delay(ack_dly));
  clk_ratio_ctrl uut (.mclk(mclk), .arst_n(arst_n), .ratio_select(rsel),
    .bypass_half_rate_qualifier(qual), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pll_enable(pll), .core_clk_en(core_en),
    .bus_clk_en(bus_en), .core_mult_x2(mult), .ratio_reserved(rsvd));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  // straps are taken once after release, so each code needs its own reset
  task automatic do_reset(input logic [5:0] c, input int n);
    @(posedge mclk);
    arst_n <= 1'b0;
    code <= c;
    repeat (n) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= wd;
    // wait for the acknowledge; only the bench timeout ends a hang
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd = rdat;
    chk("wb ack", ack, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hf;
    wdat = 32'h0;
    code = 6'h3c;
    qual_run = 1'b0;
    do_reset(6'h3c, 20);
    for (i = 0; i < 18; i++) begin
      do_reset(codes[i], 2);
      chk("mult", mult, mx2[i]);
      chk("pll", pll, i < 15);
      chk("core en", core_en, i < 16);
      chk("reserved", rsvd, i == 17);
      chk("bus en", bus_en, i < 15);
      chk("ack delay", ack_dly, i == 15);
      wb(1'b0, 4'h4, 32'h0, d);
      chk("status", d, {8'h0, mx2[i], 7'h0, i == 17,
        i < 15 ? 2'h1 : (i == 15 ? 2'h2 : 2'h0), codes[i]});
    end
    $display("test done: ratio table");
    // bus enable follows the qualifier one edge later, so half rate
    qual_run <= 1'b1;
    do_reset(6'h0c, 2);
    repeat (6) begin
      @(posedge mclk);
      q = qual;
      #1;
      chk("bypass bus en", bus_en, q);
    end
    $display("test done: bypass");
    do_reset(6'h1a, 2);
    // a strap moved after capture must be ignored until the next reset
    code <= 6'h26;
    wb(1'b1, 4'h0, 32'h3, d);
    repeat (3) @(posedge mclk);
    #1;
    chk("switch mult", mult, 8'h18);
    wb(1'b0, 4'h0, 32'h0, d);
    chk("ctrl readback", d, 32'h3);
    wb(1'b1, 4'h4, 32'hffffffff, d);
    wb(1'b0, 4'h4, 32'h0, d);
    chk("status ro", d, 32'h0018_005a);
    wb(1'b0, 4'h8, 32'h0, d);
    chk("unmapped", d, 32'h0);
    wb(1'b1, 4'h0, 32'h0, d);
    repeat (3) @(posedge mclk);
    #1;
    chk("switch off mult", mult, 8'h30);
    $display("test done: ctrl and status");
    test_done();
  end
endmodule // clk_ratio_ctrl_tb
`default_nettype wire
